// file: inc/sarcc_pkg.sv
/*
 * Constants for the successive-approximation conversion control block:
 * register offsets, field positions, reset values, channel codes and
 * conversion timing in converter clock cycles.
 * Assumes a byte-wide register port with a 3-bit address.
 */
package sarcc_pkg;

    // Register offsets
    localparam logic [2:0] OFS_RESULT_LOW   = 3'h0;
    localparam logic [2:0] OFS_RESULT_HIGH  = 3'h1;
    localparam logic [2:0] OFS_CONTROL_A    = 3'h2;
    localparam logic [2:0] OFS_CONTROL_B    = 3'h3;
    localparam logic [2:0] OFS_INPUT_SELECT = 3'h4;

    // Converter control A fields
    localparam int CA_ENABLE_BIT    = 7;
    localparam int CA_START_BIT     = 6;
    localparam int CA_AUTO_BIT      = 5;
    localparam int CA_DONE_BIT      = 4;
    localparam int CA_IRQ_EN_BIT    = 3;
    localparam int CA_PRESCALE_LSB  = 0;

    // Converter control B fields
    localparam int CB_TRIG_SRC_LSB  = 0;

    // Input select fields
    localparam int IS_REF_LSB       = 6;
    localparam int IS_LEFT_BIT      = 5;
    localparam int IS_CHAN_LSB      = 0;

    // Reset values
    localparam logic [7:0] CONTROL_A_RST    = 8'h00;
    localparam logic [2:0] TRIG_SRC_RST     = 3'h0;
    localparam logic [7:0] INPUT_SELECT_RST = 8'h00;
    localparam logic [9:0] RESULT_RST       = 10'h000;

    // Reference select codes
    localparam logic [1:0] REF_EXTERNAL     = 2'h0;
    localparam logic [1:0] REF_SUPPLY       = 2'h1;
    localparam logic [1:0] REF_INTERNAL     = 2'h3;

    // Channel codes
    localparam logic [4:0] CH_DIFF_FIRST    = 5'h08;
    localparam logic [4:0] CH_DIFF_LAST     = 5'h17;
    localparam logic [4:0] CH_BANDGAP       = 5'h1e;
    localparam logic [4:0] CH_GROUND        = 5'h1f;
    localparam logic [2:0] DIFF_COMMON_NEG  = 3'h1;

    // Trigger source that makes conversions free-running
    localparam logic [2:0] TRIG_SRC_FREE    = 3'h0;

    // Conversion timing in converter clock cycles
    localparam logic [4:0] NORMAL_LEN       = 5'd13;
    localparam logic [4:0] FIRST_LEN        = 5'd25;
    localparam logic [4:0] NORMAL_SAMPLE    = 5'd1;
    localparam logic [4:0] FIRST_SAMPLE     = 5'd13;
    localparam logic [9:0] SAR_FIRST_TRIAL  = 10'h200;

    typedef enum logic [1:0] {
        SARCC_IDLE = 2'b00,
        SARCC_WAIT = 2'b01,
        SARCC_CONV = 2'b10
    } sarcc_state_t;

endpackage : sarcc_pkg

// file: hdl/sarcc_top.sv
/*
 * Conversion control for a 10-bit successive-approximation converter:
 * register port, prescaler, start and trigger logic, SAR sequencing,
 * result alignment and read interlock, selection of reference and input.
 * Assumes an analog front end that drives a comparator output which is
 * high when the held input exceeds the trial code, and trigger flags
 * from peripherals on the same clock.
 */
`timescale 1ns/10ps

// Behaviour
// - Ten-bit result; zero is ground, full code is reference minus one step.
// - Reference is analog supply, internal 1.1V, or external reference pin.
// - Single-ended input is any pin, ground or the bandgap voltage.
// - Sixteen differential pairs; seven use pin one as common negative.
// - Single-ended bypasses the differential amplifier; pairs convert difference.
// - Selections apply only when enabled; disabled converter is powered down.
// - Result right-aligned by default, left-aligned when left adjust set.
// - Low byte read blocks result updates; completions meanwhile are discarded.
// - High byte read re-enables result updates.
// - Completion raises the done flag even when the result is discarded.
// - Writing one starts; start reads one during conversion; cleared at end unless free running.
// - Channel changes during conversion apply only after it completes.
// - Auto trigger enabled by its bit, source by the trigger select field.
// - Rising trigger edge resets prescaler and starts a conversion.
// - Trigger held high or rising during conversion starts nothing.
// - Trigger flags set regardless of enables; owner clears before next trigger.
// - Done flag as source runs conversions back to back, flag ignored.
// - Software start still works while auto trigger is enabled.
// - Conversion lasts 13 converter clocks, first after enable lasts 25.
// - Prescaler counts only while enabled, held reset otherwise.
// - At completion write result, set flag, clear start in single mode.
module sarcc_top
    import sarcc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // Register port
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    output logic      [7:0] rd_data_o,
    // Trigger flags, sources 1 to 7
    input  wire logic [6:0] trigger_i,
    // Analog front end
    input  wire logic       cmp_i,
    output logic            power_o,
    output logic            ref_supply_o,
    output logic            ref_internal_o,
    output logic      [2:0] pos_sel_o,
    output logic      [2:0] neg_sel_o,
    output logic            diff_en_o,
    output logic            bandgap_sel_o,
    output logic            ground_sel_o,
    output logic            sample_o,
    output logic      [9:0] dac_code_o,
    // Completion interrupt condition
    output logic            done_irq_o
);

    // Channel decode: {diff, bandgap, ground, pos[2:0], neg[2:0]}
    function automatic logic [8:0] chan_decode(input logic [4:0] ch);
        logic [3:0] idx;
        logic [8:0] r;
        idx = 4'(ch - CH_DIFF_FIRST);
        r   = 9'h000;
        if (ch < CH_DIFF_FIRST) begin
            r = {3'b000, ch[2:0], 3'h0};
        end else if (ch <= CH_DIFF_LAST) begin
            if (idx < 4'd7) begin
                r[8]   = 1'b1;
                r[5:3] = (idx == 4'd0) ? 3'h0 : 3'(idx + 4'd1);
                r[2:0] = DIFF_COMMON_NEG;
            end else if (idx < 4'd14) begin
                r[8]   = 1'b1;
                r[5:3] = 3'(idx - 4'd6);
                r[2:0] = 3'h0;
            end else begin
                r[8]   = 1'b1;
                r[5:3] = (idx == 4'd14) ? 3'h3 : 3'h5;
                r[2:0] = (idx == 4'd14) ? 3'h2 : 3'h4;
            end
        end else if (ch == CH_BANDGAP) begin
            r[7] = 1'b1;
        end else begin
            r[6] = 1'b1;
        end
        return r;
    endfunction : chan_decode

    // Last prescaler count for a division field
    function automatic logic [6:0] presc_last(input logic [2:0] ps);
        logic [6:0] r;
        r = (ps == 3'h0) ? 7'h01 : 7'((8'h01 << ps) - 8'h01);
        return r;
    endfunction : presc_last

    // Register state
    logic         enable_q;
    logic         auto_q;
    logic         flag_q;
    logic         irq_en_q;
    logic   [2:0] prescale_q;
    logic   [2:0] trig_src_q;
    logic   [1:0] ref_q;
    logic         left_q;
    logic   [4:0] chan_q;
    logic   [9:0] result_q;
    logic         lock_q;

    // Sequencer state
    sarcc_state_t state_q;
    logic   [6:0] presc_q;
    logic   [4:0] step_q;
    logic         first_q;
    logic         conv_first_q;
    logic   [9:0] dac_q;
    logic         cmp_meta_q;
    logic         cmp_q;
    logic         trig_prev_q;

    // Decoded strobes
    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_sel;
    logic rd_low;
    logic rd_high;
    logic en_next;
    logic sw_start;
    logic trig_level;
    logic trig_edge;
    logic free_run;
    logic tick;
    logic [4:0] conv_len;
    logic [4:0] sample_step;
    logic [4:0] trial_base;
    logic [4:0] trial_idx;
    logic conv_last;
    logic complete;
    logic busy;
    logic [8:0] chan_dec;

    assign wr_ctrl_a = wr_en_i && (addr_i == OFS_CONTROL_A);
    assign wr_ctrl_b = wr_en_i && (addr_i == OFS_CONTROL_B);
    assign wr_sel    = wr_en_i && (addr_i == OFS_INPUT_SELECT);
    assign rd_low    = rd_en_i && (addr_i == OFS_RESULT_LOW);
    assign rd_high   = rd_en_i && (addr_i == OFS_RESULT_HIGH);
    assign en_next   = wr_ctrl_a ? wr_data_i[CA_ENABLE_BIT] : enable_q;
    assign busy      = (state_q != SARCC_IDLE);
    // Only a written one starts; zero is ignored
    assign sw_start  = wr_ctrl_a && wr_data_i[CA_START_BIT] && en_next;
    assign trig_level = (trig_src_q == TRIG_SRC_FREE) ? 1'b0
                                                      : trigger_i[3'(trig_src_q - 3'h1)];
    // Edges only count while idle
    assign trig_edge = auto_q && enable_q && trig_level && !trig_prev_q
                       && (state_q == SARCC_IDLE);
    assign free_run  = auto_q && (trig_src_q == TRIG_SRC_FREE);
    assign tick      = enable_q && (presc_q == presc_last(prescale_q));
    assign conv_len    = conv_first_q ? FIRST_LEN : NORMAL_LEN;
    assign sample_step = conv_first_q ? FIRST_SAMPLE : NORMAL_SAMPLE;
    assign trial_base  = 5'(sample_step + 5'd1);
    assign trial_idx   = 5'(step_q - trial_base);
    assign conv_last   = (step_q == 5'(conv_len - 5'd1));
    assign complete    = (state_q == SARCC_CONV) && tick && conv_last;
    assign chan_dec    = chan_decode(chan_q);

    // Comparator synchroniser
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_meta_q <= 1'b0;
            cmp_q      <= 1'b0;
        end else if (ce_i) begin
            cmp_meta_q <= cmp_i;
            cmp_q      <= cmp_meta_q;
        end
    end

    // Control register A
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_q   <= CONTROL_A_RST[CA_ENABLE_BIT];
            auto_q     <= CONTROL_A_RST[CA_AUTO_BIT];
            irq_en_q   <= CONTROL_A_RST[CA_IRQ_EN_BIT];
            prescale_q <= CONTROL_A_RST[CA_PRESCALE_LSB +: 3];
        end else if (ce_i && wr_ctrl_a) begin
            enable_q   <= wr_data_i[CA_ENABLE_BIT];
            auto_q     <= wr_data_i[CA_AUTO_BIT];
            irq_en_q   <= wr_data_i[CA_IRQ_EN_BIT];
            prescale_q <= wr_data_i[CA_PRESCALE_LSB +: 3];
        end
    end

    // Done flag, set wins over a write-one clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_q <= CONTROL_A_RST[CA_DONE_BIT];
        end else if (ce_i) begin
            if (complete) begin
                flag_q <= 1'b1;
            end else if (wr_ctrl_a && wr_data_i[CA_DONE_BIT]) begin
                flag_q <= 1'b0;
            end
        end
    end

    // Control register B and input select
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_src_q <= TRIG_SRC_RST;
            ref_q      <= INPUT_SELECT_RST[IS_REF_LSB +: 2];
            left_q     <= INPUT_SELECT_RST[IS_LEFT_BIT];
            chan_q     <= INPUT_SELECT_RST[IS_CHAN_LSB +: 5];
        end else if (ce_i) begin
            if (wr_ctrl_b) begin
                trig_src_q <= wr_data_i[CB_TRIG_SRC_LSB +: 3];
            end
            if (wr_sel) begin
                ref_q  <= wr_data_i[IS_REF_LSB +: 2];
                left_q <= wr_data_i[IS_LEFT_BIT];
                chan_q <= wr_data_i[IS_CHAN_LSB +: 5];
            end
        end
    end

    // Trigger edge history
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_prev_q <= 1'b0;
        end else if (ce_i) begin
            trig_prev_q <= trig_level;
        end
    end

    // Prescaler
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            presc_q <= 7'h00;
        end else if (ce_i) begin
            if (!enable_q) begin
                presc_q <= 7'h00;
            end else if (trig_edge || tick) begin
                presc_q <= 7'h00;
            end else begin
                presc_q <= 7'(presc_q + 7'h01);
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= SARCC_IDLE;
        end else if (ce_i) begin
            if (!en_next) begin
                state_q <= SARCC_IDLE;
            end else begin
                case (state_q)
                    SARCC_IDLE: begin
                        if (sw_start || trig_edge) begin
                            state_q <= SARCC_WAIT;
                        end
                    end
                    SARCC_WAIT: begin
                        if (tick) begin
                            state_q <= SARCC_CONV;
                        end
                    end
                    SARCC_CONV: begin
                        if (complete) begin
                            state_q <= free_run ? SARCC_WAIT : SARCC_IDLE;
                        end
                    end
                    default: begin
                        state_q <= SARCC_IDLE;
                    end
                endcase
            end
        end
    end

    // Step counter and first-conversion tracking
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_q       <= 5'd0;
            first_q      <= 1'b1;
            conv_first_q <= 1'b0;
        end else if (ce_i) begin
            if (!enable_q) begin
                first_q <= 1'b1;
            end
            if (state_q == SARCC_WAIT && tick) begin
                step_q       <= 5'd0;
                conv_first_q <= first_q;
                first_q      <= 1'b0;
            end else if (state_q == SARCC_CONV && tick) begin
                step_q <= 5'(step_q + 5'd1);
            end
        end
    end

    // Sample pulse and successive approximation
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sample_o <= 1'b0;
            dac_q    <= RESULT_RST;
        end else if (ce_i) begin
            sample_o <= 1'b0;
            if (state_q == SARCC_CONV && tick) begin
                if (step_q == sample_step) begin
                    sample_o <= 1'b1;
                    dac_q    <= SAR_FIRST_TRIAL;
                end else if (step_q >= trial_base && trial_idx < 5'd10) begin
                    if (!cmp_q) begin
                        dac_q[4'(5'd9 - trial_idx)] <= 1'b0;
                    end
                    if (trial_idx < 5'd9) begin
                        dac_q[4'(5'd8 - trial_idx)] <= 1'b1;
                    end
                end
            end
        end
    end

    // Result store and read interlock
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_q <= RESULT_RST;
            lock_q   <= 1'b0;
        end else if (ce_i) begin
            if (complete && !lock_q) begin
                result_q <= dac_q;
            end
            if (rd_low) begin
                lock_q <= 1'b1;
            end else if (rd_high) begin
                lock_q <= 1'b0;
            end
        end
    end

    // Front-end selection, held during a conversion
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_o        <= 1'b0;
            ref_supply_o   <= 1'b0;
            ref_internal_o <= 1'b0;
            diff_en_o      <= 1'b0;
            bandgap_sel_o  <= 1'b0;
            ground_sel_o   <= 1'b0;
            pos_sel_o      <= 3'h0;
            neg_sel_o      <= 3'h0;
        end else if (ce_i) begin
            power_o <= enable_q;
            if (!enable_q) begin
                ref_supply_o   <= 1'b0;
                ref_internal_o <= 1'b0;
                diff_en_o      <= 1'b0;
                bandgap_sel_o  <= 1'b0;
                ground_sel_o   <= 1'b0;
                pos_sel_o      <= 3'h0;
                neg_sel_o      <= 3'h0;
            end else if (state_q != SARCC_CONV) begin
                ref_supply_o   <= (ref_q == REF_SUPPLY);
                ref_internal_o <= (ref_q == REF_INTERNAL);
                diff_en_o      <= chan_dec[8];
                bandgap_sel_o  <= chan_dec[7];
                ground_sel_o   <= chan_dec[6];
                pos_sel_o      <= chan_dec[5:3];
                neg_sel_o      <= chan_dec[2:0];
            end
        end
    end

    // Trial code and interrupt condition
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dac_code_o <= RESULT_RST;
            done_irq_o <= 1'b0;
        end else if (ce_i) begin
            dac_code_o <= dac_q;
            done_irq_o <= flag_q && irq_en_q;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (ce_i) begin
            rd_data_o <= 8'h00;
            if (rd_en_i) begin
                case (addr_i)
                    OFS_RESULT_LOW: begin
                        rd_data_o <= left_q ? {result_q[1:0], 6'h00}
                                            : result_q[7:0];
                    end
                    OFS_RESULT_HIGH: begin
                        rd_data_o <= left_q ? result_q[9:2]
                                            : {6'h00, result_q[9:8]};
                    end
                    OFS_CONTROL_A: begin
                        rd_data_o <= {enable_q, busy, auto_q, flag_q,
                                      irq_en_q, prescale_q};
                    end
                    OFS_CONTROL_B: begin
                        rd_data_o <= {5'h00, trig_src_q};
                    end
                    OFS_INPUT_SELECT: begin
                        rd_data_o <= {ref_q, left_q, chan_q};
                    end
                    default: begin
                        rd_data_o <= 8'h00;
                    end
                endcase
            end
        end
    end

endmodule : sarcc_top

// file: verification/sarcc_props.sv
/*
 * Checker for the conversion control block: register read port,
 * power and selection outputs, sample pulse and completion timing.
 * Assumes binding to sarcc_top with the clock enable held high.
 */
`timescale 1ns/10ps
module sarcc_props
    import sarcc_pkg::*;
(
    // Clock, reset, register port
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic       wr_en_i,
    input wire logic       rd_en_i,
    input wire logic [7:0] rd_data_o,
    // Analog front end and completion
    input wire logic       power_o,
    input wire logic       ref_supply_o,
    input wire logic       ref_internal_o,
    input wire logic [2:0] pos_sel_o,
    input wire logic [2:0] neg_sel_o,
    input wire logic       diff_en_o,
    input wire logic       bandgap_sel_o,
    input wire logic       ground_sel_o,
    input wire logic       sample_o,
    input wire logic       done_irq_o
);
    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Selection stays put after the sample
    sequence s_sel_held;
        $stable({ref_supply_o, ref_internal_o, pos_sel_o, neg_sel_o, diff_en_o}) [*8];
    endsequence
    // No completion right after the sample
    sequence s_no_done;
        !$rose(done_irq_o) [*8];
    endsequence

    rd_idle_zero_a: assert property (!$past(rd_en_i) |-> rd_data_o == 8'h00)
        else $error("read data not zero outside read");
    rd_unmapped_a: assert property (rd_en_i && addr_i > OFS_INPUT_SELECT |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    power_follow_a: assert property (
        wr_en_i && addr_i == OFS_CONTROL_A |-> ##2 power_o == $past(wr_data_i[7], 2))
        else $error("power does not follow enable");
    sample_pulse_a: assert property (sample_o |-> power_o ##1 !sample_o)
        else $error("sample pulse bad");
    sel_frozen_a: assert property (sample_o |=> s_sel_held)
        else $error("selection moved during conversion");
    early_done_a: assert property (sample_o |=> s_no_done)
        else $error("completion too soon after sample");
    ref_onehot_a: assert property (!(ref_supply_o && ref_internal_o))
        else $error("two references at once");
    se_bypass_a: assert property ((bandgap_sel_o || ground_sel_o) |-> !diff_en_o)
        else $error("amplifier in single ended path");
    diff_pair_a: assert property (diff_en_o |-> pos_sel_o != neg_sel_o)
        else $error("differential pair not distinct");
endmodule : sarcc_props

bind sarcc_top sarcc_props u_props (.ref_clk_i, .rst_n_i, .addr_i, .wr_data_i, .wr_en_i,
    .rd_en_i, .rd_data_o, .power_o, .ref_supply_o, .ref_internal_o, .pos_sel_o, .neg_sel_o,
    .diff_en_o, .bandgap_sel_o, .ground_sel_o, .sample_o, .done_irq_o);

// file: verification/sarcc_afe_model.sv
/*
 * Behavioural analog front end: sample-and-hold and comparator.
 * Assumes the block's sample pulse, trial code and power output.
 */
`timescale 1ns/10ps
module sarcc_afe_model (
    // Control side
    input  wire logic       ref_clk_i,
    input  wire logic       power_i,
    input  wire logic       sample_i,
    input  wire logic [9:0] dac_i,
    // Input level as a code
    input  wire logic [9:0] vin_i,
    output logic            cmp_o
);
    logic [9:0] held_q = 10'h000;
    logic       wander_q = 1'b0;

    always_ff @(posedge ref_clk_i) begin
        if (sample_i) begin
            held_q <= vin_i;
        end
        wander_q <= ~wander_q;
    end

    // Input sits half a step above its code; unpowered output wanders
    assign cmp_o = power_i ? (held_q >= dac_i) : wander_q;
endmodule : sarcc_afe_model

// file: verification/tb_sar_conversion_control.sv
/*
 * Testbench: register tasks drive conversions, alignment, interlock,
 * triggers and free running. Assumes sarcc_top and the front end model.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_sar_conversion_control;
    import sarcc_pkg::*;
    logic       ref_clk_i = 1'b0;
    logic       rst_n_i   = 1'b0;
    logic [2:0] addr_i    = 3'h0;
    logic [7:0] wr_data_i = 8'h00;
    logic       wr_en_i   = 1'b0;
    logic       rd_en_i   = 1'b0;
    logic [6:0] trigger_i = 7'h00;
    logic [9:0] vin       = 10'h2b5;
    logic [9:0] dac_code_o;
    logic [7:0] rd_data_o, d;
    logic [2:0] pos_sel_o, neg_sel_o;
    logic       cmp_i, power_o, ref_supply_o, ref_internal_o, diff_en_o;
    logic       bandgap_sel_o, ground_sel_o, sample_o, done_irq_o;
    int         failures = 0, checks_done = 0, cyc, n;

    always #12.5 ref_clk_i = ~ref_clk_i;

    sarcc_top DUT (.ref_clk_i, .rst_n_i, .ce_i(1'b1), .addr_i, .wr_data_i, .wr_en_i,
        .rd_en_i, .rd_data_o, .trigger_i, .cmp_i, .power_o, .ref_supply_o, .ref_internal_o,
        .pos_sel_o, .neg_sel_o, .diff_en_o, .bandgap_sel_o, .ground_sel_o, .sample_o,
        .dac_code_o, .done_irq_o);
    sarcc_afe_model u_afe (.ref_clk_i, .power_i(power_o), .sample_i(sample_o),
        .dac_i(dac_code_o), .vin_i(vin), .cmp_o(cmp_i));

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        addr_i    <= a;
        wr_data_i <= v;
        wr_en_i   <= 1'b1;
        @(posedge ref_clk_i);
        wr_en_i   <= 1'b0;
    endtask : wr

    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        addr_i  <= a;
        rd_en_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_en_i <= 1'b0;
        #1 d = rd_data_o;
        `CHK(d, e)
    endtask : rc

    // Cycles until the completion condition shows
    task automatic wdone;
        repeat (2) @(posedge ref_clk_i);
        #1 cyc = 2;
        while (done_irq_o !== 1'b1 && cyc < 300) begin
            @(posedge ref_clk_i);
            #1 cyc++;
        end
        `CHK(cyc < 300, 1'b1)
    endtask : wdone

    task automatic results;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    initial begin
        repeat (6000) @(posedge ref_clk_i);
        failures++;
        results();
    end

    initial begin
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (n = 0; n < 8; n++) rc(3'(n), 8'h00);
        wr(OFS_INPUT_SELECT, 8'h43);
        wr(OFS_CONTROL_A, 8'h8a);
        repeat (3) @(posedge ref_clk_i);
        `CHK({power_o, ref_supply_o, ref_internal_o, diff_en_o, pos_sel_o}, 7'h63)
        wr(OFS_CONTROL_A, 8'hca);
        rc(OFS_CONTROL_A, 8'hca);
        wdone;
        `CHK(cyc inside {[98:110]}, 1'b1)
        rc(OFS_CONTROL_A, 8'h9a);
        rc(OFS_RESULT_LOW, 8'hb5);
        rc(OFS_RESULT_HIGH, 8'h02);
        wr(OFS_INPUT_SELECT, 8'h63);
        rc(OFS_RESULT_LOW, 8'h40);
        vin = 10'h13c;
        wr(OFS_CONTROL_A, 8'hda);
        wdone;
        `CHK(cyc inside {[50:62]}, 1'b1)
        `CHK(done_irq_o, 1'b1)
        rc(OFS_RESULT_HIGH, 8'had);
        wr(OFS_CONTROL_A, 8'hda);
        repeat (6) @(posedge ref_clk_i);
        wr(OFS_INPUT_SELECT, 8'h6a);
        wr(OFS_CONTROL_A, 8'h8a);
        rc(OFS_CONTROL_A, 8'hca);
        `CHK({diff_en_o, pos_sel_o}, 4'h3)
        wdone;
        rc(OFS_RESULT_HIGH, 8'h4f);
        repeat (2) @(posedge ref_clk_i);
        `CHK({diff_en_o, pos_sel_o, neg_sel_o}, 7'h59)
        wr(OFS_CONTROL_B, 8'h02);
        wr(OFS_CONTROL_A, 8'hba);
        trigger_i <= 7'h02;
        repeat (10) @(posedge ref_clk_i);
        trigger_i <= 7'h00;
        repeat (2) @(posedge ref_clk_i);
        trigger_i <= 7'h02;
        wdone;
        `CHK(done_irq_o, 1'b1)
        wr(OFS_CONTROL_A, 8'hba);
        trigger_i <= 7'h03;
        repeat (80) @(posedge ref_clk_i);
        rc(OFS_CONTROL_A, 8'haa);
        wr(OFS_CONTROL_A, 8'hea);
        rc(OFS_CONTROL_A, 8'hea);
        wdone;
        wr(OFS_CONTROL_B, 8'h00);
        wr(OFS_CONTROL_A, 8'hba);
        repeat (80) @(posedge ref_clk_i);
        rc(OFS_CONTROL_A, 8'haa);
        wr(OFS_CONTROL_A, 8'hea);
        wdone;
        vin = 10'h0c8;
        repeat (130) @(posedge ref_clk_i);
        rc(OFS_CONTROL_A, 8'hfa);
        rc(OFS_RESULT_LOW, 8'h00);
        rc(OFS_RESULT_HIGH, 8'h32);
        wr(OFS_CONTROL_A, 8'h1a);
        repeat (3) @(posedge ref_clk_i);
        `CHK({power_o, ref_supply_o, diff_en_o, pos_sel_o, neg_sel_o}, 9'h000)
        wr(OFS_CONTROL_A, 8'hca);
        wdone;
        `CHK(cyc inside {[98:110]}, 1'b1)
        wr(OFS_INPUT_SELECT, 8'hde);
        repeat (2) @(posedge ref_clk_i);
        `CHK({ref_supply_o, ref_internal_o, diff_en_o, bandgap_sel_o, ground_sel_o}, 5'h0a)
        wr(OFS_INPUT_SELECT, 8'h1f);
        repeat (2) @(posedge ref_clk_i);
        `CHK({ref_supply_o, ref_internal_o, diff_en_o, bandgap_sel_o, ground_sel_o}, 5'h01)
        results();
    end
endmodule : tb_sar_conversion_control
